// *** adc_conversion_sequencer.v ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"
module adc_conversion_sequencer #(
	parameter RC_DIV = 100
) (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire [3:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rdata,
	input  wire       cmp_in,
	input  wire [3:0] compare_unit_mode,
	input  wire       special_trigger,
	output reg        timer_clear,
	output reg  [3:0] channel_select,
	output reg        sample_switch,
	output reg        discharge,
	output reg        irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_DISCH = 3'h1;
	localparam ST_SAMPLE = 3'h2;
	localparam ST_SLOT = 3'h3;
	localparam ST_ACQ = 3'h4;
	localparam ST_CONV = 3'h5;
	localparam ST_WAIT = 3'h6;

	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [7:0] res_hi_reg;
	reg  [7:0] res_lo_reg;
	reg        converter_on;
	reg        go_reg;
	reg  [5:0] ctl_one_reg;
	reg        right_just;
	reg  [2:0] acq_time_select;
	reg  [2:0] conv_clock_select;
	reg  [1:0] irq_status;
	reg  [1:0] irq_mask;
	reg  [7:0] cnt_reg;
	reg  [3:0] trig_mode_s1;
	reg  [3:0] trig_mode_s2;
	reg        trig_s1;
	reg        trig_s2;
	reg        trig_s3;
	reg        cmp_s1;
	reg        cmp_s2;
	wire       tick;
	wire [9:0] code;
	wire       eng_busy;
	wire       eng_done;
	wire       trig_edge;
	wire       trig_go;
	wire       go_clear_wr;
	wire       go_set_wr;
	wire       abort_now;
	wire       start_conv;
	wire [1:0] irq_set;

	// acquisition code to bit periods; only 000 and 010 are fixed by behaviour
	function [3:0] acq_periods;
		input [2:0] s;
		begin
			case (s)
			3'h1: acq_periods = 4'h2;
			3'h2: acq_periods = 4'h4;
			3'h3: acq_periods = 4'h6;
			3'h4: acq_periods = 4'h8;
			3'h5: acq_periods = 4'hC;
			3'h6: acq_periods = 4'hE;
			3'h7: acq_periods = 4'hF;
			default: acq_periods = 4'h0;
			endcase
		end
	endfunction

	// trigger and comparator come from outside this clock, so two flops first
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trig_s1      <= 1'b0;
			trig_s2      <= 1'b0;
			trig_s3      <= 1'b0;
			trig_mode_s1 <= 4'h0;
			trig_mode_s2 <= 4'h0;
			cmp_s1       <= 1'b0;
			cmp_s2       <= 1'b0;
		end else begin
			trig_s1      <= special_trigger;
			trig_s2      <= trig_s1;
			trig_s3      <= trig_s2;
			trig_mode_s1 <= compare_unit_mode;
			trig_mode_s2 <= trig_mode_s1;
			cmp_s1       <= cmp_in;
			cmp_s2       <= cmp_s1;
		end
	end

	assign trig_edge = trig_s2 & ~trig_s3;
	assign trig_go = trig_edge && converter_on && trig_mode_s2 == `TRIGGER_MODE;
	assign go_set_wr = wr_en && addr == `ADDR_CONTROL_ZERO && wdata[`BIT_GO];
	assign go_clear_wr = wr_en && addr == `ADDR_CONTROL_ZERO && !wdata[`BIT_GO];
	// aborting only by a go clear write mid-conversion; switching the converter off with go set aborts just the engine
	assign abort_now = (state_reg == ST_CONV) && go_clear_wr;
	assign start_conv = (state_reg == ST_SLOT && tick) ||
		(state_reg == ST_ACQ && tick && cnt_reg == 8'h01);
	assign irq_set = {abort_now, eng_done};

	conv_clock_div #(
		.RC_DIV (RC_DIV)
	) u_div (
		.mclk  (mclk),
		.rst_n (rst_n),
		.run   (converter_on),
		.sel   (conv_clock_select),
		.tick  (tick)
	);

	sar_engine u_sar (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.start  (start_conv),
		// switching off must not leave a frozen conversion that finishes later
		.abort  (abort_now | ~converter_on),
		.tick   (tick),
		.cmp_in (cmp_s2),
		.code   (code),
		.busy   (eng_busy),
		.done   (eng_done)
	);

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: if (converter_on) state_next = ST_DISCH;
		ST_DISCH: if (tick) state_next = ST_SAMPLE;
		ST_SAMPLE: begin
			if (go_reg)
				state_next = (acq_time_select == 3'h0) ? ST_SLOT : ST_ACQ;
		end
		ST_SLOT: if (tick) state_next = ST_CONV;
		ST_ACQ: if (tick && cnt_reg == 8'h01) state_next = ST_CONV;
		ST_CONV: if (abort_now || eng_done) state_next = ST_WAIT;
		ST_WAIT: if (tick && cnt_reg == 8'h01) state_next = ST_DISCH;
		default: state_next = ST_IDLE;
		endcase
		if (!converter_on)
			state_next = ST_IDLE;
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_SAMPLE && state_next == ST_ACQ)
				cnt_reg <= {4'h0, acq_periods(acq_time_select)};
			else if (state_reg == ST_CONV && state_next == ST_WAIT)
				cnt_reg <= {4'h0, `WAIT_PERIODS};
			else if (tick && cnt_reg != 8'h00)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end

	// register file; the sleep slot of code 000 is one bit period here
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			res_hi_reg        <= 8'h00;
			res_lo_reg        <= 8'h00;
			converter_on      <= 1'b0;
			go_reg            <= 1'b0;
			channel_select    <= 4'h0;
			ctl_one_reg       <= 6'h00;
			right_just        <= 1'b0;
			acq_time_select   <= 3'h0;
			conv_clock_select <= 3'h0;
			irq_status        <= 2'h0;
			irq_mask          <= 2'h0;
		end else begin
			if (wr_en) begin
				case (addr)
				`ADDR_RESULT_HIGH: res_hi_reg <= wdata;
				`ADDR_RESULT_LOW: res_lo_reg <= wdata;
				`ADDR_CONTROL_ZERO: begin
					converter_on   <= wdata[`BIT_CONVERTER_ON];
					// go in the same write as power-up is honoured, though discouraged
					go_reg         <= wdata[`BIT_GO] & wdata[`BIT_CONVERTER_ON];
					channel_select <= wdata[`CHAN_LSB+3:`CHAN_LSB];
				end
				`ADDR_CONTROL_ONE: ctl_one_reg <= wdata[5:0];
				`ADDR_CONTROL_TWO: begin
					right_just        <= wdata[`BIT_RESULT_RIGHT];
					acq_time_select   <= wdata[`ACQ_LSB+2:`ACQ_LSB];
					conv_clock_select <= wdata[`CLK_LSB+2:`CLK_LSB];
				end
				`ADDR_IRQ_MASK: irq_mask <= wdata[1:0];
				default: ;
				endcase
			end
			if (trig_go)
				go_reg <= 1'b1;
			if (eng_done) begin
				go_reg <= 1'b0;
				if (right_just) begin
					res_hi_reg <= {6'h00, code[9:8]};
					res_lo_reg <= code[7:0];
				end else begin
					res_hi_reg <= code[9:2];
					res_lo_reg <= {code[1:0], 6'h00};
				end
			end
			// abort path writes nothing to the result pair
			if (abort_now)
				go_reg <= 1'b0;
			// read clears, but a same-cycle event still lands
			if (rd_en && addr == `ADDR_IRQ_STATUS)
				irq_status <= irq_set;
			else
				irq_status <= irq_status | irq_set;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata         <= 8'h00;
			timer_clear   <= 1'b0;
			sample_switch <= 1'b0;
			discharge     <= 1'b0;
			irq           <= 1'b0;
		end else begin
			timer_clear   <= trig_edge && trig_mode_s2 == `TRIGGER_MODE;
			sample_switch <= state_next == ST_SAMPLE || state_next == ST_SLOT ||
				state_next == ST_ACQ;
			discharge     <= state_next == ST_DISCH;
			irq           <= |((irq_status | irq_set) & irq_mask);
			rdata         <= 8'h00;
			if (rd_en) begin
				case (addr)
				`ADDR_RESULT_HIGH: rdata <= res_hi_reg;
				`ADDR_RESULT_LOW: rdata <= res_lo_reg;
				`ADDR_CONTROL_ZERO: rdata <= {2'h0, channel_select, go_reg, converter_on};
				`ADDR_CONTROL_ONE: rdata <= {2'h0, ctl_one_reg};
				`ADDR_CONTROL_TWO: rdata <= {right_just, 1'b0, acq_time_select,
					conv_clock_select};
				`ADDR_IRQ_STATUS: rdata <= {6'h00, irq_status};
				`ADDR_IRQ_MASK: rdata <= {6'h00, irq_mask};
				default: rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // adc_conversion_sequencer
`default_nettype wire

// *** adc_seq_defs.vh ***
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
// register addresses on the plain port
`define ADDR_RESULT_HIGH   4'h0
`define ADDR_RESULT_LOW    4'h1
`define ADDR_CONTROL_ZERO  4'h2
`define ADDR_CONTROL_ONE   4'h3
`define ADDR_CONTROL_TWO   4'h4
`define ADDR_IRQ_STATUS    4'h5
`define ADDR_IRQ_MASK      4'h6
// control zero fields
`define BIT_CONVERTER_ON   0
`define BIT_GO             1
`define CHAN_LSB           2
// control two fields
`define BIT_RESULT_RIGHT   7
`define ACQ_LSB            3
`define CLK_LSB            0
// irq status bits
`define IRQ_DONE           0
`define IRQ_ABORT          1
// compare unit trigger mode
`define TRIGGER_MODE       4'hB
// sequence lengths in bit periods, the sleep slot in clock cycles, and the default rc divide
`define CONV_PERIODS       4'hB
`define WAIT_PERIODS       4'h2
`define DISCHARGE_PERIODS  4'h1
`define SLEEP_SLOT_CYCLES  8'h04
`define RC_DIV_DEFAULT     8'h64
`endif

// *** conv_clock_div.v ***
`timescale 1ns/10ps
`default_nettype none
module conv_clock_div #(
	parameter RC_DIV = 100
) (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       run,
	input  wire [2:0] sel,
	output reg        tick
);
	reg  [7:0] cnt_reg;
	wire [7:0] limit;

	// x11 selects the internal rc source, modelled as a fixed divide
	function [7:0] div_of;
		input [2:0] s;
		begin
			case (s)
			3'h0: div_of = 8'h02;
			3'h4: div_of = 8'h04;
			3'h1: div_of = 8'h08;
			3'h5: div_of = 8'h10;
			3'h2: div_of = 8'h20;
			3'h6: div_of = 8'h40;
			default: div_of = RC_DIV[7:0];
			endcase
		end
	endfunction

	assign limit = div_of(sel);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 8'h00;
			tick    <= 1'b0;
		end else if (cnt_reg >= limit - 8'h01) begin
			cnt_reg <= 8'h00;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tick    <= 1'b0;
		end
	end
endmodule // conv_clock_div
`default_nettype wire

// *** sar_engine.v ***
`timescale 1ns/10ps
`default_nettype none
module sar_engine (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       start,
	input  wire       abort,
	input  wire       tick,
	input  wire       cmp_in,
	output reg  [9:0] code,
	output reg        busy,
	output reg        done
);
	reg [3:0] step_reg;
	reg [9:0] trial_reg;

	// eleven bit periods: one settle slot, then one bit each
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg  <= 4'h0;
			trial_reg <= 10'h000;
			code      <= 10'h000;
			busy      <= 1'b0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
			end else if (start) begin
				busy      <= 1'b1;
				step_reg  <= 4'h0;
				trial_reg <= 10'h200;
				code      <= 10'h000;
			end else if (busy && tick) begin
				if (step_reg != 4'h0) begin
					code[10 - step_reg] <= cmp_in;
					trial_reg <= trial_reg >> 1;
				end
				if (step_reg == `CONV_PERIODS - 4'h1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				step_reg <= step_reg + 4'h1;
			end
		end
	end
endmodule // sar_engine
`default_nettype wire

// *** adc_conversion_sequencer_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module seq_checker (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       wr_en,
	input wire logic [3:0] compare_unit_mode,
	input wire logic       special_trigger,
	input wire logic       timer_clear,
	input wire logic [3:0] channel_select,
	input wire logic       sample_switch,
	input wire logic       discharge,
	input wire logic       irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence trig_rise;
		$rose(special_trigger) && compare_unit_mode == 4'hB;
	endsequence
	// five cycles covers the mode synchroniser and the edge detector
	sequence idle_mode;
		compare_unit_mode != 4'hB [*5];
	endsequence
	a_trig_clear: assert property (trig_rise |-> ##3 timer_clear)
		else $error("timer clear missing");
	a_clear_pulse: assert property (timer_clear |=> !timer_clear)
		else $error("timer clear too long");
	a_clear_cause: assert property (timer_clear |-> $past(special_trigger, 3))
		else $error("stray timer clear");
	a_mode_block: assert property (idle_mode |-> !timer_clear)
		else $error("trigger taken in wrong mode");
	a_disch_excl: assert property (!(discharge && sample_switch))
		else $error("discharge while sampling");
	a_disch_first: assert property ($rose(sample_switch) |-> $past(discharge))
		else $error("sampling without discharge");
	a_chan_hold: assert property (!$past(wr_en) |-> $stable(channel_select))
		else $error("channel moved");
	a_done_wait: assert property ($rose(irq) && !$past(wr_en) |-> !sample_switch [*4])
		else $error("sampling too soon");
endmodule // seq_checker
bind adc_conversion_sequencer seq_checker chk (.mclk, .rst_n, .wr_en, .compare_unit_mode,
	.special_trigger, .timer_clear, .channel_select, .sample_switch, .discharge, .irq);
`default_nettype wire

// *** trig_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module trig_partner #(
	parameter int PERIOD = 60
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic timer_clear,
	input  wire logic armed,
	output var  logic special_trigger
);
	logic [7:0] count;
	// free-running timer, wraps if nobody clears it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			count <= 8'h00;
		else if (timer_clear)
			count <= 8'h00;
		else
			count <= count + 8'h01;
	end
	// match held four cycles so the synchroniser cannot miss it
	assign special_trigger = armed && count >= PERIOD && count < PERIOD + 4;
endmodule // trig_partner
`default_nettype wire

// *** adc_conversion_sequencer_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, v); end end
module adc_conversion_sequencer_bench;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       cmp_in = 1'b0;
	logic [3:0] mode = 4'h0;
	logic       armed = 1'b0;
	wire logic [7:0] rdata;
	wire logic       trig;
	wire logic       tclr;
	wire logic [3:0] chan;
	wire logic       samp;
	wire logic       irq;
	int         bad_count = 0;
	int         tests_run = 0;
	logic [7:0] rv;
	always #20 mclk = ~mclk;
	adc_conversion_sequencer #(.RC_DIV(4)) dut (.mclk, .rst_n, .addr, .wdata, .wr_en, .rd_en,
		.rdata, .cmp_in, .compare_unit_mode(mode), .special_trigger(trig), .timer_clear(tclr),
		.channel_select(chan), .sample_switch(samp), .discharge(), .irq);
	trig_partner cc (.mclk, .rst_n, .timer_clear(tclr), .armed, .special_trigger(trig));
	task automatic close_out();
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 rv = rdata;
		`CHK(n, e, rv)
	endtask
	// sel 1 waits for the timer clear pulse, 0 for the interrupt
	task automatic await(input bit sel, input int n, output int i);
		for (i = 0; i < n; i++) begin
			@(posedge mclk);
			#1;
			if ((sel ? tclr : irq) === 1'b1)
				break;
		end
		if (i == n) begin
			`CHK("wait", 1'b1, 1'b0)
			close_out();
		end
	endtask
	task automatic t_regs();
		wr(`ADDR_CONTROL_ONE, 8'h2A);
		wr(`ADDR_IRQ_MASK, 8'h03);
		rchk("ctrl1", `ADDR_CONTROL_ONE, 8'h2A);
		rchk("unmapped", 4'hF, 8'h00);
		wr(`ADDR_RESULT_HIGH, 8'h5A);
		rchk("res hi", `ADDR_RESULT_HIGH, 8'h5A);
	endtask
	task automatic t_conv();
		int n;
		cmp_in <= 1'b1;
		wr(`ADDR_CONTROL_TWO, 8'h80);
		wr(`ADDR_CONTROL_ZERO, 8'h15);
		repeat (8) @(posedge mclk);
		#1 `CHK("chan", 4'h5, chan)
		`CHK("sampling", 1'b1, samp)
		wr(`ADDR_CONTROL_ZERO, 8'h17);
		repeat (6) @(posedge mclk);
		#1 `CHK("slot over", 1'b0, samp)
		await(1'b0, 60, n);
		`CHK("conv len", 19, n)
		rchk("status", `ADDR_IRQ_STATUS, 8'h01);
		rchk("go clear", `ADDR_CONTROL_ZERO, 8'h15);
		rchk("res hi", `ADDR_RESULT_HIGH, 8'h03);
		rchk("res lo", `ADDR_RESULT_LOW, 8'hFF);
		`CHK("irq off", 1'b0, irq)
		`CHK("resampling", 1'b1, samp)
	endtask
	task automatic t_abort();
		cmp_in <= 1'b0;
		wr(`ADDR_CONTROL_TWO, 8'h90);
		wr(`ADDR_CONTROL_ZERO, 8'h17);
		repeat (5) @(posedge mclk);
		#1 `CHK("acquiring", 1'b1, samp)
		repeat (10) @(posedge mclk);
		#1 `CHK("converting", 1'b0, samp)
		wr(`ADDR_CONTROL_ZERO, 8'h15);
		rchk("abort", `ADDR_IRQ_STATUS, 8'h02);
		rchk("kept hi", `ADDR_RESULT_HIGH, 8'h03);
		rchk("kept lo", `ADDR_RESULT_LOW, 8'hFF);
	endtask
	task automatic t_trig();
		int n;
		mode <= 4'hB;
		armed <= 1'b1;
		await(1'b0, 400, n);
		rchk("trig done", `ADDR_IRQ_STATUS, 8'h01);
		wr(`ADDR_CONTROL_ZERO, 8'h14);
		await(1'b1, 400, n);
		mode <= 4'h0;
		repeat (60) @(posedge mclk);
		rchk("off idle", `ADDR_IRQ_STATUS, 8'h00);
		repeat (600) begin
			@(posedge mclk);
			#1 `CHK("mode refused", 1'b0, tclr)
		end
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_conv();
		t_abort();
		t_trig();
		close_out();
	end
endmodule // adc_conversion_sequencer_bench
`default_nettype wire
